/* design/link_quality_monitor.sv */
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
`include "link_quality_monitor_defines.svh"
module link_quality_monitor
(
    input  wire logic                                  sys_clk,
    input  wire logic                                  reset,
    input  wire link_quality_monitor_pkg::wb_req_t     wb_req,
    output link_quality_monitor_pkg::wb_rsp_t          wb_rsp,
    input  wire logic                                  link_up_100,
    input  wire link_quality_monitor_pkg::dsp_params_t params,
    output logic                                       irq,
    output link_quality_monitor_pkg::dsp_ctrl_t        dsp_ctrl
);
    import link_quality_monitor_pkg::*;

    localparam state_t STATE_INIT = '{
        ack:        1'b0,
        rdata:      32'h0000_0000,
        ctrl:       `CTRL_RST,
        warn:       `WARN_RST,
        armed:      1'b1,
        irq_status: `IRQ_RST,
        irq_mask:   `IRQ_RST,
        signal_detect_option:  `SIGNAL_DETECT_OPTION_RST,
        param_sel:  SEL_EQUALIZER_COEF,
        thr_sel:    1'b0,
        thr_lo:     {`NUM_PARAMS{`THR_MIN}},
        thr_hi:     {`NUM_PARAMS{`THR_MAX}},
        irq:        1'b0,
        dsp:        3'h0
    };

    state_t                               st_reg;
    state_t                               st_next;
    logic [`NUM_PARAMS-1:0][`PARAM_W-1:0] pv;
    logic                                 monitor_active;
    logic [9:0]                           viol;
    logic [9:0]                           new_warn;
    logic [`NUM_PARAMS-1:0]               restart_req;
    logic                                 restart_any;
    logic                                 lq_event;
    logic                                 req_new;
    logic [5:0]                           idx;
    logic                                 read_clear;
    logic                                 thr_go;
    logic [2:0]                           thr_wsel;
    logic                                 thr_whigh;
    logic [`PARAM_W-1:0]                  thr_wdata;
    logic [`PARAM_W-1:0]                  thr_rd;
    logic [1:0]                           irq_set;

    assign pv = params;

    assign monitor_active = st_reg.ctrl[`MON_EN_BIT-`RESTART_LSB] & link_up_100;

    // a warning that is already latched cannot retrigger a restart
    assign new_warn = viol & ~st_reg.warn;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    genvar g;
    generate
        for (g = 0; g < `NUM_PARAMS; g++) begin : g_param
            threshold_check u_check (
                .value     (pv[g]),
                .thr_low   (st_reg.thr_lo[g]),
                .thr_high  (st_reg.thr_hi[g]),
                .active    (monitor_active),
                .high_viol (viol[2*g+1]),
                .low_viol  (viol[2*g])
            );

            assign restart_req[g] = st_reg.ctrl[g] & (new_warn[2*g+1] | new_warn[2*g]);

            chk_warn_latch:
            assert property ((viol[2*g+1] |=> st_reg.warn[2*g+1])
                             and (viol[2*g] |=> st_reg.warn[2*g]))
                else $error("violation did not latch its warning bit");

            chk_thr_disable:
            assert property ((st_reg.thr_hi[g] == `THR_MAX) |-> !viol[2*g+1])
                else $error("disabled high threshold flagged a violation");

            chk_thr_low_off:
            assert property ((st_reg.thr_lo[g] == `THR_MIN) |-> !viol[2*g])
                else $error("disabled low threshold flagged a violation");

            chk_restart_gate:
            assert property (!st_reg.ctrl[g] |-> !restart_req[g])
                else $error("restart requested with its enable bit clear");

            chk_restart_cause:
            assert property (st_reg.ctrl[g] && (new_warn[2*g+1] || new_warn[2*g])
                             |=> st_reg.dsp.dsp_reset && st_reg.dsp.restart_adapt)
                else $error("enabled restart did not follow a new violation");
        end
    endgenerate

    assign restart_any = |restart_req;
    assign irq_set     = {restart_any, lq_event};
    assign lq_event    = st_reg.armed & (|viol);

    always_comb begin
        thr_rd = `THR_MIN;
        if (st_reg.param_sel <= `PSEL_LAST) begin
            thr_rd = st_reg.thr_sel ? st_reg.thr_hi[st_reg.param_sel]
                                    : st_reg.thr_lo[st_reg.param_sel];
        end
    end

    always_comb begin
        st_next    = st_reg;
        read_clear = 1'b0;
        thr_go     = 1'b0;
        thr_wsel   = st_reg.param_sel;
        thr_whigh  = st_reg.thr_sel;
        thr_wdata  = wb_req.dat[`THR_DATA_MSB:0];
        idx        = wb_req.adr[7:2];
        req_new    = wb_req.cyc & wb_req.stb & ~st_reg.ack;

        st_next.ack = req_new;
        st_next.dsp = 3'h0;

        if (req_new) begin
            st_next.rdata = 32'h0000_0000;
            if (idx == `LQM_CTRL_IDX) begin
                st_next.rdata = {16'h0000, st_reg.ctrl, st_reg.warn};
                if (wb_req.we && wb_req.sel[1]) begin
                    st_next.ctrl = wb_req.dat[`MON_EN_BIT:`RESTART_LSB];
                end
                read_clear = ~wb_req.we;
            end else if (idx == `THR_ACCESS_IDX) begin
                // write strobe bit always reads back as zero
                st_next.rdata = {16'h0000, 3'h0, 1'b0, st_reg.param_sel, st_reg.thr_sel, thr_rd};
                if (wb_req.we && wb_req.sel[1]) begin
                    thr_wsel          = wb_req.dat[`PSEL_MSB:`PSEL_LSB];
                    thr_whigh         = wb_req.dat[`TSEL_BIT];
                    st_next.param_sel = parameter_select_t'(thr_wsel);
                    st_next.thr_sel   = thr_whigh;
                    // data byte must be enabled for the store to happen
                    thr_go = wb_req.dat[`THR_WRITE_BIT] & wb_req.sel[0]
                             & (thr_wsel <= `PSEL_LAST);
                end
            end else if (idx == `IRQ_STATUS_IDX) begin
                st_next.rdata = {30'h0000_0000, st_reg.irq_status};
            end else if (idx == `IRQ_MASK_IDX) begin
                st_next.rdata = {30'h0000_0000, st_reg.irq_mask};
                if (wb_req.we && wb_req.sel[0]) begin
                    st_next.irq_mask = wb_req.dat[1:0];
                end
            end else if (idx == `PCS_CONFIG_IDX) begin
                st_next.rdata = {23'h00_0000, st_reg.signal_detect_option, 8'h00};
                if (wb_req.we && wb_req.sel[1]) begin
                    st_next.signal_detect_option = wb_req.dat[`SIGNAL_DETECT_OPTION_BIT];
                end
            end
        end

        if (thr_go) begin
            if (thr_whigh) begin
                st_next.thr_hi[thr_wsel] = thr_wdata;
            end else begin
                st_next.thr_lo[thr_wsel] = thr_wdata;
            end
        end

        // sticky warnings, set wins over read clear
        st_next.warn = (st_reg.warn & ~{10{read_clear}}) | viol;

        // one interrupt per read cycle; the read hands back the arm
        if (lq_event) begin
            st_next.armed = 1'b0;
        end else if (read_clear) begin
            st_next.armed = 1'b1;
        end

        // status is write-one-to-clear; a same-cycle event survives
        if (req_new && wb_req.we && wb_req.sel[0] && idx == `IRQ_STATUS_IDX) begin
            st_next.irq_status = st_reg.irq_status & ~wb_req.dat[1:0];
        end
        st_next.irq_status = st_next.irq_status | irq_set;

        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        st_next.dsp.dsp_reset     = restart_any;
        st_next.dsp.restart_adapt = restart_any;
        // link drop unless signal detect option
        st_next.dsp.link_drop     = restart_any & ~st_reg.signal_detect_option;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_reg <= STATE_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_rsp.ack = st_reg.ack;
    assign wb_rsp.dat = st_reg.rdata;
    assign irq        = st_reg.irq;
    assign dsp_ctrl   = st_reg.dsp;

    chk_monitor_gate:
    assert property (!monitor_active |-> viol == 10'h000)
        else $error("violation flagged while monitor inactive");

    chk_idle_hold:
    assert property (!monitor_active && !read_clear |=> st_reg.warn == $past(st_reg.warn))
        else $error("warnings changed while monitor inactive");

    chk_read_clear:
    assert property (read_clear && viol == 10'h000 |=> st_reg.warn == 10'h000)
        else $error("monitor read did not clear warnings");

    chk_read_data:
    assert property (req_new && !wb_req.we && idx == `LQM_CTRL_IDX
                     |=> st_reg.rdata[9:0] == $past(st_reg.warn))
        else $error("monitor read did not return latched warnings");

    chk_rearm_event:
    assert property (read_clear && !lq_event ##1 (viol != 10'h000)
                     |=> st_reg.irq_status[`IRQ_LQ_BIT])
        else $error("read did not re-arm interrupt generation");

    chk_irq_raise:
    assert property (lq_event && st_reg.irq_mask[`IRQ_LQ_BIT]
                     && !(req_new && wb_req.we && idx == `IRQ_MASK_IDX) |=> irq)
        else $error("enabled violation did not raise the interrupt");

    chk_irq_masked:
    assert property (st_reg.irq_mask == 2'h0 |-> !irq)
        else $error("interrupt raised with every source masked");

    chk_link_drop:
    assert property (restart_any |=> st_reg.dsp.link_drop == !$past(st_reg.signal_detect_option))
        else $error("link drop does not follow signal detect option");

    chk_thr_write:
    assert property (thr_go && thr_whigh |=> st_reg.thr_hi[$past(thr_wsel)] == $past(thr_wdata))
        else $error("threshold write missed the selected high entry");

    chk_bus_ack:
    assert property (st_reg.ack |=> !st_reg.ack)
        else $error("bus acknowledge held longer than one cycle");

    chk_bus_answer:
    assert property (req_new |=> st_reg.ack)
        else $error("accepted request was not acknowledged");

    chk_bus_quiet:
    assert property (!req_new |=> !st_reg.ack)
        else $error("acknowledge without an accepted request");

    chk_ctrl_write:
    assert property (req_new && wb_req.we && wb_req.sel[1] && idx == `LQM_CTRL_IDX
                     |=> st_reg.ctrl == $past(wb_req.dat[`MON_EN_BIT:`RESTART_LSB]))
        else $error("control write did not land");

    chk_ctrl_bytes:
    assert property (req_new && wb_req.we && !wb_req.sel[1] && idx == `LQM_CTRL_IDX
                     |=> st_reg.ctrl == $past(st_reg.ctrl))
        else $error("control changed without its byte enable");

    chk_warn_ro:
    assert property (req_new && wb_req.we && viol == 10'h000
                     |=> st_reg.warn == $past(st_reg.warn))
        else $error("register write changed the warnings");

    chk_clear_keeps_set:
    assert property (read_clear |=> st_reg.warn == $past(viol))
        else $error("read clear lost a same-cycle violation");

    chk_event_disarm:
    assert property (lq_event |=> !st_reg.armed)
        else $error("interrupt event did not disarm");

    chk_disarmed_quiet:
    assert property (!st_reg.armed && !read_clear |=> !st_reg.armed)
        else $error("interrupt re-armed without a monitor read");

    chk_inactive_event:
    assert property (!monitor_active |-> !lq_event)
        else $error("interrupt event while monitor inactive");

    chk_status_clear:
    assert property (req_new && wb_req.we && wb_req.sel[0] && idx == `IRQ_STATUS_IDX
                     && irq_set == 2'h0
                     |=> st_reg.irq_status
                         == ($past(st_reg.irq_status) & ~$past(wb_req.dat[1:0])))
        else $error("status write-one-to-clear misbehaved");

    chk_mask_write:
    assert property (req_new && wb_req.we && wb_req.sel[0] && idx == `IRQ_MASK_IDX
                     |=> st_reg.irq_mask == $past(wb_req.dat[1:0]))
        else $error("mask write did not land");

    chk_option_write:
    assert property (req_new && wb_req.we && wb_req.sel[1] && idx == `PCS_CONFIG_IDX
                     |=> st_reg.signal_detect_option == $past(wb_req.dat[`SIGNAL_DETECT_OPTION_BIT]))
        else $error("signal detect option write did not land");

    chk_restart_status:
    assert property (restart_any |=> st_reg.irq_status[`IRQ_RESTART_BIT])
        else $error("restart did not set its status bit");

    chk_irq_level:
    assert property (irq == |(st_reg.irq_status & st_reg.irq_mask))
        else $error("interrupt level differs from masked status");

    chk_pulse_pair:
    assert property (st_reg.dsp.dsp_reset == st_reg.dsp.restart_adapt)
        else $error("processor reset and adaptation restart split");

    chk_drop_with_reset:
    assert property (st_reg.dsp.link_drop |-> st_reg.dsp.dsp_reset)
        else $error("link drop without a processor reset");

    chk_pulse_cause:
    assert property (!restart_any |=> !st_reg.dsp.dsp_reset)
        else $error("processor reset without a new violation");

    chk_thr_low_write:
    assert property (thr_go && !thr_whigh
                     |=> st_reg.thr_lo[$past(thr_wsel)] == $past(thr_wdata))
        else $error("threshold write missed the selected low entry");

    chk_select_write:
    assert property (req_new && wb_req.we && wb_req.sel[1] && idx == `THR_ACCESS_IDX
                     |=> st_reg.param_sel == $past(wb_req.dat[`PSEL_MSB:`PSEL_LSB])
                         && st_reg.thr_sel == $past(wb_req.dat[`TSEL_BIT]))
        else $error("threshold select write did not land");

    chk_unmapped_read:
    assert property (req_new && !wb_req.we && idx < `LQM_CTRL_IDX
                     |=> st_reg.rdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    cov_warning_set: cover property (read_clear ##1 st_reg.warn != 10'h000);
    cov_irq_rise: cover property (!irq ##1 irq);
    cov_restart_drop: cover property (st_reg.dsp.dsp_reset && st_reg.dsp.link_drop);
    cov_thr_write: cover property (thr_go);
    cov_restart_status: cover property (restart_any ##1 st_reg.irq_status[`IRQ_RESTART_BIT]);
endmodule

/* design/link_quality_monitor_defines.svh */
// Operation
// - monitor runs only when enabled with 100 Mb link
// - high threshold at max or low threshold at min never flags
// - violation raises interrupt when mask enables it
// - monitor register read clears warnings, re-arms interrupt
// - bit 14 restarts on frequency control violation
// - bit 13 restarts on frequency offset violation
// - bit 11 restarts on digital gain violation
// - bit 10 restarts on equalizer coefficient violation
// - restart drops link when signal detect option clear
// - bits 9/8 flag frequency control high/low
// - bits 7/6 flag frequency offset high/low
// - bits 5/4 flag baseline wander high/low
// - bits 3/2 flag digital gain high/low
// - bits 1/0 flag equalizer coefficient high/low
// - warning bits read-only, reset zero, cleared on read
// - 3-bit parameter select decodes five parameters
// - threshold select: 0 low, 1 high
`ifndef LINK_QUALITY_MONITOR_DEFINES_SVH
`define LINK_QUALITY_MONITOR_DEFINES_SVH

`define LQM_CTRL_IDX     6'h1D
`define THR_ACCESS_IDX   6'h1E
`define IRQ_STATUS_IDX   6'h20
`define IRQ_MASK_IDX     6'h21
`define PCS_CONFIG_IDX   6'h22

`define NUM_PARAMS       5
`define PARAM_W          8
`define MON_EN_BIT       15
`define RESTART_LSB      10
`define WARN_MSB         9
`define THR_WRITE_BIT    12
`define PSEL_MSB         11
`define PSEL_LSB         9
`define TSEL_BIT         8
`define THR_DATA_MSB     7
`define SIGNAL_DETECT_OPTION_BIT    8
`define IRQ_LQ_BIT       0
`define IRQ_RESTART_BIT  1
`define PSEL_LAST        3'h4

`define THR_MAX          8'hFF
`define THR_MIN          8'h00
`define CTRL_RST         6'h00
`define WARN_RST         10'h000
`define IRQ_RST          2'h0
`define SIGNAL_DETECT_OPTION_RST    1'b0

`endif

/* design/link_quality_monitor_pkg.sv */
`include "link_quality_monitor_defines.svh"
package link_quality_monitor_pkg;

    typedef logic [`PARAM_W-1:0] param_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // last field lands at index 0 when viewed as an array
    typedef struct packed {
        param_t freq_control;
        param_t freq_offset;
        param_t baseline_wander;
        param_t digital_gain;
        param_t equalizer_coef;
    } dsp_params_t;

    typedef enum logic [2:0] {
        SEL_EQUALIZER_COEF  = 3'h0,
        SEL_DIGITAL_GAIN    = 3'h1,
        SEL_BASELINE_WANDER = 3'h2,
        SEL_FREQ_OFFSET     = 3'h3,
        SEL_FREQ_CONTROL    = 3'h4
    } parameter_select_t;

    typedef struct packed {
        logic dsp_reset;
        logic restart_adapt;
        logic link_drop;
    } dsp_ctrl_t;

    typedef struct packed {
        logic                                   ack;
        logic [31:0]                            rdata;
        logic [5:0]                             ctrl;
        logic [9:0]                             warn;
        logic                                   armed;
        logic [1:0]                             irq_status;
        logic [1:0]                             irq_mask;
        logic                                   signal_detect_option;
        parameter_select_t                      param_sel;
        logic                                   thr_sel;
        logic [`NUM_PARAMS-1:0][`PARAM_W-1:0]   thr_lo;
        logic [`NUM_PARAMS-1:0][`PARAM_W-1:0]   thr_hi;
        logic                                   irq;
        dsp_ctrl_t                              dsp;
    } state_t;

endpackage

/* design/threshold_check.sv */
`timescale 1ns/10ps
`include "link_quality_monitor_defines.svh"
module threshold_check
(
    input  wire logic [`PARAM_W-1:0] value,
    input  wire logic [`PARAM_W-1:0] thr_low,
    input  wire logic [`PARAM_W-1:0] thr_high,
    input  wire logic                active,
    output logic                     high_viol,
    output logic                     low_viol
);
    assign high_viol = active && (thr_high != `THR_MAX) && (value > thr_high);
    assign low_viol  = active && (thr_low != `THR_MIN) && (value < thr_low);
endmodule

/* dv/link_quality_monitor_tb.sv */
`timescale 1ns/10ps
module link_quality_monitor_tb;
    import link_quality_monitor_pkg::*;

    logic            sys_clk;
    logic            reset;
    wb_req_t         wb_req;
    wb_rsp_t         wb_rsp;
    logic            link_up_100;
    logic [4:0][7:0] pv;
    dsp_params_t     params;
    logic            irq;
    dsp_ctrl_t       dsp_ctrl;
    logic [31:0]     exp_q[$];
    int              error_cnt;
    int              cmp_count;
    int              cyc_cnt;
    int              seed;
    int              n_rst;
    int              n_adapt;
    int              n_drop;

    // index 4 is frequency control, index 0 equalizer coefficient
    assign params = pv;

    link_quality_monitor i_link_quality_monitor (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .wb_req      (wb_req),
        .wb_rsp      (wb_rsp),
        .link_up_100 (link_up_100),
        .params      (params),
        .irq         (irq),
        .dsp_ctrl    (dsp_ctrl)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic fail(input string msg);
        error_cnt++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail($sformatf("%s got %h expected %h", what, got, exp));
        end
    endtask

    task automatic end_sim;
        if (exp_q.size() != 0) begin
            fail("reads left unanswered");
        end
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] rnd(input int lo, input int span);
        return 8'(lo + ($unsigned($random(seed)) % span));
    endfunction

    // request held until ack is seen at a rising edge, then released
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("no bus acknowledge");
        end
        wb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        bus(1'b1, adr, sel, dat);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, adr, 4'hF, 32'h0);
    endtask

    // out-of-range value for four cycles, then back to a random in-range value
    task automatic violate(input int p, input logic [7:0] bad);
        @(posedge sys_clk);
        pv[p] <= bad;
        repeat (4) @(posedge sys_clk);
        pv[p] <= rnd(8'h21, 8'hBF);
    endtask

    always @(posedge sys_clk) begin
        if (wb_rsp.ack === 1'b1 && wb_req.cyc === 1'b1 && wb_req.we === 1'b0) begin
            if (exp_q.size() == 0) begin
                fail("read data with no expectation");
            end else begin
                chk(wb_rsp.dat, exp_q.pop_front(), "read data");
            end
        end
        if (dsp_ctrl.dsp_reset === 1'b1) n_rst++;
        if (dsp_ctrl.restart_adapt === 1'b1) n_adapt++;
        if (dsp_ctrl.link_drop === 1'b1) n_drop++;
        cyc_cnt++;
        if (cyc_cnt == 6000) begin
            fail("run took too long");
            end_sim();
        end
    end

    initial begin
        int lim;
        seed = 43053;
        reset = 1'b1;
        link_up_100 = 1'b0;
        wb_req = '0;
        pv = {5{8'h80}};
        error_cnt = 0;
        cmp_count = 0;
        cyc_cnt = 0;
        n_rst = 0;
        n_adapt = 0;
        n_drop = 0;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rd(8'h74, 32'h0);
        rd(8'h78, 32'h0);
        rd(8'h80, 32'h0);
        rd(8'h84, 32'h0);
        rd(8'h88, 32'h0);
        wr(8'h10, 4'hF, 32'hFFFF);
        rd(8'h10, 32'h0);
        $display("reset values done");
        for (int p = 0; p < 5; p++) begin
            for (int hi = 0; hi < 2; hi++) begin
                lim = hi ? 32'hE0 : 32'h20;
                wr(8'h78, 4'h3, 32'h1000 | (p << 9) | (hi << 8) | lim);
                rd(8'h78, (p << 9) | (hi << 8) | lim);
            end
        end
        $display("threshold access done");
        wr(8'h84, 4'h1, 32'h1);
        wr(8'h74, 4'h2, 32'h8000);
        link_up_100 <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            for (int hi = 0; hi < 2; hi++) begin
                violate(p, hi ? rnd(8'hE1, 31) : rnd(8'h00, 32));
                chk(irq, 32'h1, "irq after violation");
                rd(8'h74, 32'h8000 | (1 << (2 * p + hi)));
                rd(8'h74, 32'h8000);
                wr(8'h80, 4'h1, 32'h1);
                repeat (2) @(posedge sys_clk);
                chk(irq, 32'h0, "irq after clear");
            end
        end
        $display("warnings done");
        wr(8'h78, 4'h3, 32'h1000 | (1 << 9));
        wr(8'h78, 4'h3, 32'h1000 | (1 << 9) | (1 << 8) | 32'hFF);
        violate(1, 8'h00);
        violate(1, 8'hFF);
        rd(8'h74, 32'h8000);
        wr(8'h78, 4'h3, 32'h1000 | (1 << 9) | (1 << 8) | 32'hE0);
        link_up_100 <= 1'b0;
        violate(0, 8'h00);
        rd(8'h74, 32'h8000);
        link_up_100 <= 1'b1;
        wr(8'h74, 4'h2, 32'h0);
        violate(0, 8'h00);
        rd(8'h74, 32'h0);
        wr(8'h74, 4'h1, 32'hFC00);
        rd(8'h74, 32'h0);
        $display("qualification done");
        wr(8'h84, 4'h1, 32'h0);
        wr(8'h74, 4'h2, 32'h8000);
        violate(0, 8'h00);
        chk(irq, 32'h0, "masked irq");
        rd(8'h80, 32'h1);
        rd(8'h74, 32'h8001);
        wr(8'h80, 4'h1, 32'h1);
        $display("mask done");
        for (int p = 0; p < 5; p++) begin
            wr(8'h88, 4'h2, (p % 2) << 8);
            wr(8'h74, 4'h2, 32'h8000 | (1 << (10 + p)));
            @(negedge sys_clk);
            n_rst = 0;
            n_adapt = 0;
            n_drop = 0;
            violate(p, rnd(8'hE1, 31));
            chk(n_rst, 32'h1, "processor reset pulses");
            chk(n_adapt, 32'h1, "adaptation restart pulses");
            chk(n_drop, (p % 2) ? 32'h0 : 32'h1, "link drop pulses");
            lim = 32'h8000 | (1 << (10 + p)) | (1 << (2 * p + 1));
            rd(8'h74, lim);
        end
        rd(8'h80, 32'h3);
        wr(8'h84, 4'h1, 32'h2);
        chk(irq, 32'h1, "restart event irq");
        $display("restart done");
        end_sim();
    end

endmodule
